// file: hdl/rf_synth_pkg.sv
/*
 * Constants for the synthesizer lock and output power control block:
 * I/O register offsets, field positions, reset values and counter sizes.
 * Assumes a 6-bit-addressed I/O space of 8-bit registers reached by the processor core.
 */
package rf_synth_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam logic [5:0] ADDR_ATTEN = 6'h14;
  localparam logic [5:0] ADDR_TRIM = 6'h16;
  localparam logic [5:0] ADDR_LOCK_CFG = 6'h17;
  localparam int COARSE_LSB = 3;
  localparam int FINE_LSB = 0;
  localparam int WINDOW_LSB = 6;
  localparam int TRIM_SPARE_BIT = 5;
  localparam int UNLOCK_EN_BIT = 7;
  localparam int FORCE_BIT = 6;
  localparam int BLACKOUT_LSB = 3;
  localparam int SETTLE_LSB = 0;
  localparam logic [5:0] ATTEN_RESET = 6'h00;
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [7:0] LOCK_CFG_RESET = 8'h00;
  localparam logic [2:0] COARSE_MAX = 3'h5;
  localparam logic [2:0] FINE_MAX = 3'h5;
  localparam logic [5:0] COARSE_STEP_DB = 6'h06;
  localparam logic [1:0] WINDOW_INVALID = 2'h3;
  localparam int REF_CNT_W = 11;
  localparam int REF_BASE_DELAY = 8;
  typedef enum logic [1:0] {
    ST_ACQUIRE = 2'b01,
    ST_LOCKED = 2'b10
  } lock_state_e;
endpackage

// file: hdl/ref_delay_counter.sv
/*
 * Reference clock delay counter: counts ref ticks up to BASE << sel.
 * Assumes tick is a one-cycle enable in the clk domain.
 */
`timescale 1ns/1ps
module ref_delay_counter #(
  parameter int CNT_W = rf_synth_pkg::REF_CNT_W,
  parameter int BASE = rf_synth_pkg::REF_BASE_DELAY
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic [2:0] sel,
  output logic done
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] term;

  // Doubling per code: 8, 16, ... 1024
  assign term = CNT_W'(BASE) << sel;
  // Compare with >= so a smaller selection mid-count still completes
  assign done = (cnt_r >= term);

  always_ff @(posedge clk)
  begin
    if (rst || clear)
    begin
      cnt_r <= '0;
    end
    else if (tick && !done)
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Count moves only on a reference tick, so length is measured in ref clocks
  property p_hold_between_ticks;
    @(posedge clk) disable iff (rst)
      !tick && !clear |=> cnt_r == $past(cnt_r);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) // [R17]
    else $error("Delay counter moved without a reference tick");
endmodule

// file: hdl/rf_synth_ctrl.sv
/*
 * Synthesizer control: output attenuation, oscillator capacitor trim with
 * control-voltage window readback, and PLL lock/unlock detection.
 * Assumes all inputs are synchronous to clk, ref_tick is a one-cycle
 * pulse per crystal reference period, and cycle_slip is a one-cycle pulse.
 */
`timescale 1ns/1ps
//
// Contract
// [R1] Coarse field steps attenuation by 6 dB, codes 0..5; 6 and 7 invalid.
// [R2] Fine field steps attenuation by 1 dB, codes 0..5; 6 and 7 invalid.
// [R3] Applied attenuation is coarse plus fine; all zeros gives full power.
// [R4] Five-bit trim switches tank capacitance linearly, 0.03 pF per step.
// [R5] Trim bits 7:6 are read-only comparators; bits 5:0 writable, reset zero.
// [R6] Window reads 00 inside, 01 below, 10 above; 11 never appears.
// [R7] Config bit 7 enables unlock detection; zero leaves it inactive.
// [R8] Config bit 6 forces lock indication high regardless of counters.
// [R9] After blackout, count slips; drop lock when slip count reached.
// [R10] Blackout length doubles per code, 8 up to 1024 reference clocks.
// [R11] Blackout clears on amp key rise if enabled, lock rise, or clear bit.
// [R12] Lock counter raises lock after counting its length uninterrupted.
// [R13] Lock counter restarts on slip, synth off, out-of-lock, low frequency.
// [R14] Lock count length doubles per code, 8 up to 1024 reference clocks.
// [R15] Slip tolerance codes 0..3 declare unlock after 1..4 slips.
// [R16] Settled status is high whenever the synthesizer is locked.
// [R17] Counters advance on reference clock; lock is registered in clk domain.
module rf_synth_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic ref_tick,
  input wire logic cycle_slip,
  input wire logic out_of_lock,
  input wire logic ref_freq_low,
  input wire logic fb_freq_low,
  input wire logic synth_enable,
  input wire logic amp_key,
  input wire logic blackout_on_amp_start,
  input wire logic unlock_counter_clear,
  input wire logic [1:0] slip_tolerance,
  input wire logic vco_below_lower,
  input wire logic vco_above_upper,
  output logic [2:0] coarse_atten,
  output logic [2:0] fine_atten,
  output logic [5:0] atten_db,
  output logic atten_invalid,
  output logic [4:0] osc_cap_trim,
  output logic synth_locked
);
  logic [5:0] atten_r;
  logic [5:0] trim_r;
  logic [1:0] window_r;
  logic [7:0] lock_cfg_r;
  logic [7:0] rdata_nxt;
  logic [2:0] coarse_sat;
  logic [2:0] fine_sat;
  logic unlock_detect_enable;
  logic force_detect_true;
  logic [2:0] blackout_length_select;
  logic [2:0] settle_count_select;
  rf_synth_pkg::lock_state_e state_r;
  rf_synth_pkg::lock_state_e state_nxt;
  logic amp_key_q;
  logic lock_restart;
  logic lock_rise;
  logic blackout_clear;
  logic settle_done;
  logic blackout_done;
  logic slip_counted;
  logic slip_hit;
  logic [1:0] slip_cnt_r;

  assign unlock_detect_enable = lock_cfg_r[rf_synth_pkg::UNLOCK_EN_BIT];
  assign force_detect_true = lock_cfg_r[rf_synth_pkg::FORCE_BIT];
  assign blackout_length_select = lock_cfg_r[rf_synth_pkg::BLACKOUT_LSB +: 3];
  assign settle_count_select = lock_cfg_r[rf_synth_pkg::SETTLE_LSB +: 3];

  // Register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      atten_r <= rf_synth_pkg::ATTEN_RESET;
      trim_r <= rf_synth_pkg::TRIM_RESET; // [R5]
      lock_cfg_r <= rf_synth_pkg::LOCK_CFG_RESET;
    end
    else if (io_wr)
    begin
      if (io_addr == rf_synth_pkg::ADDR_ATTEN)
      begin
        atten_r <= io_wdata[5:0];
      end
      else if (io_addr == rf_synth_pkg::ADDR_TRIM)
      begin
        trim_r <= io_wdata[5:0]; // [R5]
      end
      else if (io_addr == rf_synth_pkg::ADDR_LOCK_CFG)
      begin
        lock_cfg_r <= io_wdata;
      end
    end
  end

  // Comparators are sampled every cycle; no reset, value unknown at start
  always_ff @(posedge clk)
  begin
    window_r <= {vco_above_upper, vco_below_lower}; // [R6]
  end

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (io_addr == rf_synth_pkg::ADDR_ATTEN)
    begin
      rdata_nxt = {2'h0, atten_r};
    end
    else if (io_addr == rf_synth_pkg::ADDR_TRIM)
    begin
      rdata_nxt = {window_r, trim_r}; // [R5]
    end
    else if (io_addr == rf_synth_pkg::ADDR_LOCK_CFG)
    begin
      rdata_nxt = lock_cfg_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      io_rdata <= 8'h00;
    end
    else if (io_rd)
    begin
      io_rdata <= rdata_nxt;
    end
  end

  // Invalid codes saturate to the largest valid step, never above 35 dB
  assign coarse_sat = (atten_r[5:3] > rf_synth_pkg::COARSE_MAX) ?
                      rf_synth_pkg::COARSE_MAX : atten_r[5:3]; // [R1]
  assign fine_sat = (atten_r[2:0] > rf_synth_pkg::FINE_MAX) ?
                    rf_synth_pkg::FINE_MAX : atten_r[2:0]; // [R2]

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      coarse_atten <= 3'h0;
      fine_atten <= 3'h0;
      atten_db <= 6'h00;
      atten_invalid <= 1'b0;
    end
    else
    begin
      coarse_atten <= coarse_sat;
      fine_atten <= fine_sat;
      atten_db <= {3'h0, coarse_sat} * rf_synth_pkg::COARSE_STEP_DB
                  + {3'h0, fine_sat}; // [R3]
      atten_invalid <= (atten_r[5:3] > rf_synth_pkg::COARSE_MAX) ||
                       (atten_r[2:0] > rf_synth_pkg::FINE_MAX); // [R1] [R2]
    end
  end

  // Capacitance is the code times 0.03 pF, so the code drives the array as is
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      osc_cap_trim <= 5'h00;
    end
    else
    begin
      osc_cap_trim <= trim_r[4:0]; // [R4]
    end
  end

  // Lock counter restart conditions
  assign lock_restart = cycle_slip || !synth_enable || out_of_lock ||
                        ref_freq_low || fb_freq_low; // [R13]

  ref_delay_counter u_settle_cnt (
    .clk(clk),
    .rst(rst),
    .clear(lock_restart),
    .tick(ref_tick), // [R17]
    .sel(settle_count_select), // [R14]
    .done(settle_done)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      amp_key_q <= 1'b0;
    end
    else
    begin
      amp_key_q <= amp_key;
    end
  end

  assign lock_rise = (state_r == rf_synth_pkg::ST_ACQUIRE) &&
                     (state_nxt == rf_synth_pkg::ST_LOCKED);
  assign blackout_clear = (amp_key && !amp_key_q && blackout_on_amp_start) ||
                          lock_rise || unlock_counter_clear; // [R11]

  ref_delay_counter u_blackout_cnt (
    .clk(clk),
    .rst(rst),
    .clear(blackout_clear),
    .tick(ref_tick), // [R17]
    .sel(blackout_length_select), // [R10]
    .done(blackout_done)
  );

  assign slip_counted = cycle_slip && unlock_detect_enable && blackout_done &&
                        !unlock_counter_clear &&
                        (state_r == rf_synth_pkg::ST_LOCKED); // [R7] [R9]
  assign slip_hit = slip_counted && (slip_cnt_r == slip_tolerance); // [R15]

  always_ff @(posedge clk)
  begin
    if (rst || blackout_clear || state_r != rf_synth_pkg::ST_LOCKED)
    begin
      slip_cnt_r <= 2'h0;
    end
    else if (slip_counted && !slip_hit)
    begin
      slip_cnt_r <= slip_cnt_r + 2'h1; // [R9]
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      rf_synth_pkg::ST_ACQUIRE:
      begin
        if (settle_done && synth_enable)
        begin
          state_nxt = rf_synth_pkg::ST_LOCKED; // [R12]
        end
      end
      rf_synth_pkg::ST_LOCKED:
      begin
        if (!synth_enable || slip_hit)
        begin
          state_nxt = rf_synth_pkg::ST_ACQUIRE; // [R9]
        end
      end
      default:
      begin
        state_nxt = rf_synth_pkg::ST_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= rf_synth_pkg::ST_ACQUIRE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Registered lock indication; also serves as the settled status bit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      synth_locked <= 1'b0;
    end
    else
    begin
      synth_locked <= (state_r == rf_synth_pkg::ST_LOCKED) ||
                      force_detect_true; // [R8] [R16] [R17]
    end
  end

  property p_force_lock;
    @(posedge clk) disable iff (rst)
      force_detect_true |=> synth_locked;
  endproperty
  a_force_lock: assert property (p_force_lock) // [R8]
    else $error("Forced lock did not show on lock output");

  property p_unlock_disabled;
    @(posedge clk) disable iff (rst)
      (state_r == rf_synth_pkg::ST_LOCKED && !unlock_detect_enable && synth_enable)
      |=> (state_r == rf_synth_pkg::ST_LOCKED);
  endproperty
  a_unlock_disabled: assert property (p_unlock_disabled) // [R7]
    else $error("Lock dropped while unlock detection was off");

  property p_window_valid;
    @(posedge clk) disable iff (rst)
      (vco_above_upper && vco_below_lower) == 1'b0 |=>
      window_r != rf_synth_pkg::WINDOW_INVALID;
  endproperty
  a_window_valid: assert property (p_window_valid) // [R6]
    else $error("Window field reads invalid code");

  property p_atten_sum;
    @(posedge clk) disable iff (rst)
      (atten_r[5:3] <= rf_synth_pkg::COARSE_MAX && atten_r[2:0] <= rf_synth_pkg::FINE_MAX)
      |=> atten_db == 6'($past(atten_r[5:3]) * 6 + $past(atten_r[2:0]));
  endproperty
  a_atten_sum: assert property (p_atten_sum) // [R3]
    else $error("Applied attenuation is not coarse plus fine");

  property p_atten_invalid;
    @(posedge clk) disable iff (rst)
      (atten_r[5:4] == 2'h3 || atten_r[2:1] == 2'h3) |=> atten_invalid;
  endproperty
  a_atten_invalid: assert property (p_atten_invalid) // [R2]
    else $error("Invalid attenuation code not flagged");

  property p_trim_follows;
    @(posedge clk) disable iff (rst)
      io_wr && io_addr == rf_synth_pkg::ADDR_TRIM |-> ##2 osc_cap_trim == $past(io_wdata[4:0], 2);
  endproperty
  a_trim_follows: assert property (p_trim_follows) // [R4]
    else $error("Trim code did not reach capacitor array");

  property p_trim_reset;
    @(posedge clk) rst |=> trim_r == rf_synth_pkg::TRIM_RESET;
  endproperty
  a_trim_reset: assert property (p_trim_reset) // [R5]
    else $error("Trim register not cleared by reset");

  property p_lock_rise;
    @(posedge clk) disable iff (rst)
      $rose(state_r == rf_synth_pkg::ST_LOCKED) |-> $past(settle_done && synth_enable);
  endproperty
  a_lock_rise: assert property (p_lock_rise) // [R12]
    else $error("Lock rose before lock count completed");

  property p_unlock_cause;
    @(posedge clk) disable iff (rst)
      $fell(state_r == rf_synth_pkg::ST_LOCKED) |-> $past(!synth_enable || slip_hit);
  endproperty
  a_unlock_cause: assert property (p_unlock_cause) // [R9]
    else $error("Lock dropped without enough counted slips");

  property p_blackout_clear;
    @(posedge clk) disable iff (rst)
      unlock_counter_clear |=> !blackout_done;
  endproperty
  a_blackout_clear: assert property (p_blackout_clear) // [R11]
    else $error("Blackout counter not held clear");

  property p_synth_off;
    @(posedge clk) disable iff (rst)
      !synth_enable |-> ##2 (!synth_locked || $past(force_detect_true));
  endproperty
  a_synth_off: assert property (p_synth_off) // [R13]
    else $error("Lock held with synthesizer disabled");
endmodule

// file: verif/pll_far_side_model.sv
/*
 * Far-side model: crystal reference ticks, cycle slips and comparators.
 * Assumes the bench changes slip_req and window_sel after falling edges.
 */
`timescale 1ns/1ps
module pll_far_side_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic slip_req,
  input wire logic [1:0] window_sel,
  output logic ref_tick,
  output logic cycle_slip,
  output logic vco_below_lower,
  output logic vco_above_upper
);
  int div_cnt = 0;
  initial ref_tick = 1'b0;
  // Crystal runs free, reset or not
  always @(negedge clk)
  begin
    div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
    ref_tick <= (div_cnt == TICK_DIV - 1);
  end
  assign cycle_slip = slip_req;
  // Both comparators never trip together
  assign vco_below_lower = (window_sel == 2'h1);
  assign vco_above_upper = (window_sel == 2'h2);
endmodule

// file: verif/rf_synth_ctrl_tb_top.sv
/*
 * Self-checking bench for the synthesizer control block.
 * Assumes the far-side model gives one reference tick every TICK_DIV clocks.
 */
`timescale 1ns/1ps
module rf_synth_ctrl_tb_top;
  localparam int TICK_DIV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  logic ref_tick;
  logic cycle_slip;
  logic vco_below_lower;
  logic vco_above_upper;
  logic slip_req = 1'b0;
  logic [1:0] window_sel = 2'h0;
  logic [2:0] hold = 3'h0;
  logic synth_enable = 1'b0;
  logic amp_key = 1'b0;
  logic blackout_on_amp_start = 1'b0;
  logic unlock_counter_clear = 1'b0;
  logic [1:0] slip_tolerance = 2'h0;
  logic [2:0] coarse_atten;
  logic [2:0] fine_atten;
  logic [5:0] atten_db;
  logic atten_invalid;
  logic synth_locked;
  logic [4:0] osc_cap_trim;
  logic [7:0] rv;
  logic [2:0] c;
  logic [2:0] f;
  int error_cnt = 0;
  int checked = 0;
  int n;
  int tick_cnt = 0;
  logic [7:0] a_in [6] = '{8'h00, 8'h13, 8'h2d, 8'h28, 8'h36, 8'hff};
  logic [5:0] a_db [6] = '{6'h00, 6'h0f, 6'h23, 6'h1e, 6'h23, 6'h23};

  initial forever #5 clk = ~clk;

  pll_far_side_model #(.TICK_DIV(TICK_DIV)) far (.clk(clk), .slip_req(slip_req),
    .window_sel(window_sel), .ref_tick(ref_tick), .cycle_slip(cycle_slip),
    .vco_below_lower(vco_below_lower), .vco_above_upper(vco_above_upper));

  rf_synth_ctrl dut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .ref_tick(ref_tick),
    .cycle_slip(cycle_slip), .out_of_lock(hold[0]), .ref_freq_low(hold[1]),
    .fb_freq_low(hold[2]), .synth_enable(synth_enable), .amp_key(amp_key),
    .blackout_on_amp_start(blackout_on_amp_start),
    .unlock_counter_clear(unlock_counter_clear), .slip_tolerance(slip_tolerance),
    .vco_below_lower(vco_below_lower), .vco_above_upper(vco_above_upper),
    .coarse_atten(coarse_atten), .fine_atten(fine_atten), .atten_db(atten_db),
    .atten_invalid(atten_invalid), .osc_cap_trim(osc_cap_trim),
    .synth_locked(synth_locked));

  task automatic end_sim();
    $display("checked %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [10:0] exp, input logic [10:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk);
    io_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    d = io_rdata;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic slip_chk(input logic exp);
    @(negedge clk);
    slip_req = 1'b1;
    @(negedge clk);
    slip_req = 1'b0;
    cyc(4);
    cmp("locked after slip", 11'(exp), 11'(synth_locked));
  endtask

  // Ticks as the design saw them at its rising edges; read back at falling edges
  always @(posedge clk) tick_cnt <= tick_cnt + int'(ref_tick);

  // Returns on a falling edge so the caller may drive inputs at once
  task automatic wait_lock(output int cnt);
    int start;
    start = tick_cnt;
    cnt = 0;
    for (int i = 0; i < 6000; i++)
    begin
      @(negedge clk);
      cnt = tick_cnt - start;
      if (synth_locked === 1'b1)
        return;
    end
    error_cnt++;
    $display("unexpected lock wait: expected lock, seen none");
    end_sim();
  endtask

  initial
  begin
    cyc(6);
    rst = 1'b0;
    cmp("locked", 11'h0, 11'(synth_locked));
    rd(6'h16, rv);
    cmp("trim", 11'h0, 11'(rv[5:0]));
    rd(6'h17, rv);
    cmp("cfg", 11'h0, 11'(rv));
    wr(6'h15, 8'hff);
    rd(6'h15, rv);
    cmp("unmapped", 11'h0, 11'(rv));
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      wr(rf_synth_pkg::ADDR_ATTEN, a_in[i]);
      cyc(2);
      c = a_in[i][5:3];
      f = a_in[i][2:0];
      cmp("coarse", 11'((c > 3'h5) ? 3'h5 : c), 11'(coarse_atten));
      cmp("fine", 11'((f > 3'h5) ? 3'h5 : f), 11'(fine_atten));
      cmp("db", 11'(a_db[i]), 11'(atten_db));
      cmp("invalid", 11'((c > 3'h5) || (f > 3'h5)), 11'(atten_invalid));
      rd(rf_synth_pkg::ADDR_ATTEN, rv);
      cmp("atten rd", 11'(a_in[i] & 8'h3f), 11'(rv));
    end
    $display("attenuation rows done");
    wr(6'h16, 8'hea);
    for (int w = 0; w < 3; w++)
    begin
      window_sel = 2'(w);
      cyc(2);
      rd(6'h16, rv);
      cmp("trim rd", 11'({2'(w), 6'h2a}), 11'(rv));
    end
    cmp("cap trim", 11'h0a, 11'(osc_cap_trim));
    $display("trim test done");
    for (int k = 0; k < 3; k++)
    begin
      synth_enable = 1'b0;
      wr(6'h17, 8'(k));
      cyc(2);
      synth_enable = 1'b1;
      wait_lock(n);
      cmp("lock ticks", 11'(8 << k), 11'(n));
    end
    synth_enable = 1'b0;
    cyc(4);
    cmp("locked off", 11'h0, 11'(synth_locked));
    wr(6'h17, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      hold = 3'(1 << i);
      synth_enable = 1'b1;
      cyc(20 * TICK_DIV);
      cmp("held lock", 11'h0, 11'(synth_locked));
      hold = 3'h0;
      wait_lock(n);
      synth_enable = 1'b0;
      cyc(4);
    end
    $display("lock counter test done");
    wr(6'h17, 8'h88);
    synth_enable = 1'b1;
    wait_lock(n);
    cyc(12 * TICK_DIV);
    slip_chk(1'b1);
    cyc(6 * TICK_DIV);
    slip_chk(1'b0);
    slip_tolerance = 2'h1;
    wr(6'h17, 8'h80);
    wait_lock(n);
    cyc(12 * TICK_DIV);
    slip_chk(1'b1);
    slip_chk(1'b0);
    slip_tolerance = 2'h0;
    blackout_on_amp_start = 1'b1;
    wait_lock(n);
    cyc(12 * TICK_DIV);
    amp_key = 1'b1;
    cyc(2 * TICK_DIV);
    slip_chk(1'b1);
    amp_key = 1'b0;
    cyc(12 * TICK_DIV);
    unlock_counter_clear = 1'b1;
    slip_chk(1'b1);
    unlock_counter_clear = 1'b0;
    cyc(3 * TICK_DIV);
    slip_chk(1'b1);
    cyc(12 * TICK_DIV);
    slip_chk(1'b0);
    wr(6'h17, 8'h00);
    wait_lock(n);
    cyc(12 * TICK_DIV);
    slip_chk(1'b1);
    synth_enable = 1'b0;
    cyc(4);
    wr(6'h17, 8'h40);
    cyc(2);
    cmp("forced", 11'h1, 11'(synth_locked));
    wr(6'h17, 8'h00);
    cyc(3);
    cmp("unforced", 11'h0, 11'(synth_locked));
    $display("unlock test done");
    // Mid-run reset with every register away from its reset value
    wr(rf_synth_pkg::ADDR_ATTEN, 8'h2d);
    wr(6'h16, 8'h1f);
    wr(6'h17, 8'h40);
    cyc(3);
    rst = 1'b1;
    cyc(6);
    rst = 1'b0;
    cmp("reset locked", 11'h0, 11'(synth_locked));
    cmp("reset coarse", 11'h0, 11'(coarse_atten));
    cmp("reset db", 11'h0, 11'(atten_db));
    cmp("reset cap trim", 11'h0, 11'(osc_cap_trim));
    rd(6'h16, rv);
    cmp("reset trim", 11'h0, 11'(rv[5:0]));
    rd(6'h17, rv);
    cmp("reset cfg", 11'h0, 11'(rv));
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
